/* File: verilog/fpes_defines.vh */
// Constants for the flash program/erase host controller.
// Assumes a 20 MHz mclk; all times are turned into mclk cycle counts here.
// Operation
// - Host writes six-cycle sector erase sequence, optionally more 30H confirms.
// - Extra sector confirms follow within the 100 us load window.
// - Host polls status at a valid address of the operated location.
// - On limit flag set, host rereads polling bit before declaring failure.
// - Host reads toggle flag twice; running only when the two differ.
// - On limit flag set, host rechecks toggle before reporting error.
// - Host holds reset 10 us when aborting algorithm, else 500 ns.
// - Host waits 50 ns after ready returns high before write enable low.
// - Protect write pulse at least 10 us, unprotect at least 12 ms.
// - High unprotect voltage on reset pin set 4 us before next write.
`ifndef FPES_DEFINES_VH
`define FPES_DEFINES_VH

`define FPES_CLK_MHZ        20
// Command words and addresses
`define FPES_ADR_UNLOCK1    20'h00555
`define FPES_ADR_UNLOCK2    20'h002AA
`define FPES_DAT_UNLOCK1    16'h00AA
`define FPES_DAT_UNLOCK2    16'h0055
`define FPES_DAT_PROGRAM    16'h00A0
`define FPES_DAT_ERASE      16'h0080
`define FPES_DAT_CHIP       16'h0010
`define FPES_DAT_SECTOR     16'h0030
`define FPES_DAT_RESET_CMD  16'h00F0
// Status bit positions
`define FPES_BIT_POLL       7
`define FPES_BIT_TOGGLE     6
`define FPES_BIT_LIMIT      5
`define FPES_BIT_TIMEOUT    3
`define FPES_BIT_TOGGLE2    2
`define FPES_SECT_LSB       12
// Times in their own units, then cycle counts (least rounds up)
`define FPES_T_SLOAD_US     100
`define FPES_T_RB_WE_NS     50
`define FPES_T_RP_ABORT_US  10
`define FPES_T_RP_IDLE_NS   500
`define FPES_T_READY_ABORT_US 20
`define FPES_T_PROT_US      10
`define FPES_T_UNPROT_MS    12
`define FPES_T_VID_US       4
`define FPES_CYC_SLOAD      (`FPES_T_SLOAD_US * `FPES_CLK_MHZ)
`define FPES_CYC_RB_WE      ((`FPES_T_RB_WE_NS * `FPES_CLK_MHZ + 999) / 1000)
`define FPES_CYC_RP_ABORT   (`FPES_T_RP_ABORT_US * `FPES_CLK_MHZ)
`define FPES_CYC_RP_IDLE    ((`FPES_T_RP_IDLE_NS * `FPES_CLK_MHZ + 999) / 1000)
`define FPES_CYC_READY_AB   (`FPES_T_READY_ABORT_US * `FPES_CLK_MHZ)
`define FPES_CYC_PROT       (`FPES_T_PROT_US * `FPES_CLK_MHZ)
`define FPES_CYC_UNPROT     (`FPES_T_UNPROT_MS * 1000 * `FPES_CLK_MHZ)
`define FPES_CYC_VID        (`FPES_T_VID_US * `FPES_CLK_MHZ)
// Bus cycle phases: each write phase lasts this many mclk cycles, a read phase three more
`define FPES_CYC_PHASE      3
// Operation codes at the user port
`define FPES_OP_PROG        3'h0
`define FPES_OP_CHIP        3'h1
`define FPES_OP_SECT        3'h2
`define FPES_OP_RESET       3'h3
`define FPES_OP_PROTECT     3'h4
`define FPES_OP_UNPROTECT   3'h5
`define FPES_OP_READ        3'h6
// Result codes
`define FPES_RES_OK         2'h0
`define FPES_RES_FAIL       2'h1
`define FPES_RES_TOOLATE    2'h2

`endif

/* File: verilog/fpes_sync.v */
// Two-flop synchroniser bank for the flash pins entering mclk domain.
// Assumes asynchronous inputs; only the second stage is visible outside.
`timescale 1ns/10ps
module fpes_sync #(
  parameter W = 17
) (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  // Signals
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // Per-bit two-flop chains
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign dout = stage2;
endmodule // fpes_sync

/* File: verilog/fpes_host.v */
// Host controller sequencing commands into a parallel NOR flash.
// Assumes asynchronous flash pins; status reads pass a two-flop synchroniser.
`timescale 1ns/10ps
`include "fpes_defines.vh"
module fpes_host #(
  parameter [31:0] UNPROT_CYC = `FPES_CYC_UNPROT,
  parameter [31:0] OP_LIMIT   = 32'd800000000
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // User command port
  input  wire        cmd_valid,
  input  wire [2:0]  cmd_op,
  input  wire [19:0] cmd_addr,
  input  wire [15:0] cmd_data,
  input  wire        cmd_more,
  input  wire        cmd_poll_toggle,
  output reg         cmd_ready,
  output reg         done,
  output reg  [1:0]  result,
  output reg  [15:0] rd_data,
  // Flash pins
  output reg  [19:0] fl_addr,
  output reg  [15:0] fl_dq_out,
  output reg         fl_dq_oe,
  input  wire [15:0] fl_dq_in,
  output reg         fl_ce_n,
  output reg         fl_oe_n,
  output reg         fl_we_n,
  output reg         fl_reset_n,
  output reg         fl_vid_en,
  input  wire        ready_busy_output
);
  localparam S_IDLE  = 4'h0;
  localparam S_WR    = 4'h1;
  localparam S_WRH   = 4'h2;
  localparam S_RD    = 4'h3;
  localparam S_RDH   = 4'h4;
  localparam S_CHECK = 4'h5;
  localparam S_RST   = 4'h6;
  localparam S_WAIT  = 4'h7;
  localparam S_PULSE = 4'h8;
  localparam S_DONE  = 4'h9;
  localparam S_VID   = 4'hA;

  wire [16:0] sync_q;
  wire [15:0] dq_s = sync_q[15:0];
  wire        rb_s = sync_q[16];

  reg [3:0]  state;
  reg [2:0]  op;
  reg [2:0]  step;
  reg [31:0] cnt;
  reg [31:0] op_cnt;
  reg [15:0] wdata;
  reg [19:0] target;
  reg [15:0] prev_rd;
  reg        have_prev;
  reg        limit_seen;
  reg        use_toggle;
  reg        rb_low_seen;

  // Pins sampled from outside the mclk domain
  fpes_sync #(.W(17)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({ready_busy_output, fl_dq_in}),
    .dout  (sync_q)
  );

  // Next command word of the unlock sequence for each step
  reg [19:0] seq_a;
  reg [15:0] seq_d;
  always @* begin
    seq_a = `FPES_ADR_UNLOCK1;
    seq_d = `FPES_DAT_UNLOCK1;
    case (step)
      3'h0: begin seq_a = `FPES_ADR_UNLOCK1; seq_d = `FPES_DAT_UNLOCK1; end
      3'h1: begin seq_a = `FPES_ADR_UNLOCK2; seq_d = `FPES_DAT_UNLOCK2; end
      3'h2: begin
        seq_a = `FPES_ADR_UNLOCK1;
        seq_d = (op == `FPES_OP_PROG) ? `FPES_DAT_PROGRAM : `FPES_DAT_ERASE;
      end
      3'h3: begin
        if (op == `FPES_OP_PROG) begin
          seq_a = target;
          seq_d = wdata;
        end else begin
          seq_a = `FPES_ADR_UNLOCK1;
          seq_d = `FPES_DAT_UNLOCK1;
        end
      end
      3'h4: begin seq_a = `FPES_ADR_UNLOCK2; seq_d = `FPES_DAT_UNLOCK2; end
      default: begin
        seq_a = target;
        seq_d = (op == `FPES_OP_CHIP) ? `FPES_DAT_CHIP : `FPES_DAT_SECTOR;
      end
    endcase
  end

  // Last index of the write sequence for each operation
  wire [2:0] last_step = (op == `FPES_OP_PROG) ? 3'h3 : 3'h5;
  wire toggling = (dq_s[`FPES_BIT_TOGGLE] != prev_rd[`FPES_BIT_TOGGLE]);
  wire poll_done = (op == `FPES_OP_PROG) ?
                   (dq_s[`FPES_BIT_POLL] == wdata[`FPES_BIT_POLL]) :
                   dq_s[`FPES_BIT_POLL];

  // Main sequencer
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE; op <= 3'h0; step <= 3'h0; cnt <= 32'h0; op_cnt <= 32'h0;
      wdata <= 16'h0000; target <= 20'h00000; prev_rd <= 16'h0000;
      have_prev <= 1'b0; limit_seen <= 1'b0; use_toggle <= 1'b0; rb_low_seen <= 1'b0;
      cmd_ready <= 1'b0; done <= 1'b0; result <= 2'h0; rd_data <= 16'h0000;
      fl_addr <= 20'h00000; fl_dq_out <= 16'h0000; fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1; fl_oe_n <= 1'b1; fl_we_n <= 1'b1;
      fl_reset_n <= 1'b1; fl_vid_en <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state != S_IDLE)
        op_cnt <= op_cnt + 32'h1;
      case (state)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          fl_ce_n <= 1'b1; fl_oe_n <= 1'b1; fl_we_n <= 1'b1; fl_dq_oe <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op <= cmd_op; target <= cmd_addr; wdata <= cmd_data;
            use_toggle <= cmd_poll_toggle;
            step <= 3'h0; cnt <= 32'h0; op_cnt <= 32'h0;
            have_prev <= 1'b0; limit_seen <= 1'b0; rb_low_seen <= 1'b0;
            case (cmd_op)
              `FPES_OP_RESET:     begin
                // Abort length chosen once; the busy pin frees up while reset is low
                state <= S_RST; fl_reset_n <= 1'b0; step <= rb_s ? 3'h0 : 3'h1;
              end
              `FPES_OP_READ:      begin state <= S_RD; fl_addr <= cmd_addr; end
              `FPES_OP_PROTECT,
              `FPES_OP_UNPROTECT: begin state <= S_VID; fl_vid_en <= 1'b1; end
              default:            state <= S_WAIT;
            endcase
          end
        end
        // Wait out ready recovery before write enable falls
        S_WAIT: begin
          cnt <= cnt + 32'h1;
          if (!rb_s)
            cnt <= 32'h0;
          else if (cnt >= `FPES_CYC_RB_WE - 1) begin
            cnt <= 32'h0;
            state <= S_WR;
          end
        end
        // Write strobe low phase
        S_WR: begin
          fl_addr <= seq_a; fl_dq_out <= seq_d; fl_dq_oe <= 1'b1;
          fl_ce_n <= 1'b0; fl_oe_n <= 1'b1; fl_we_n <= 1'b0;
          cnt <= cnt + 32'h1;
          if (cnt >= `FPES_CYC_PHASE - 1) begin
            cnt <= 32'h0; fl_we_n <= 1'b1; state <= S_WRH;
          end
        end
        // Write strobe high phase, then next word or polling
        S_WRH: begin
          fl_we_n <= 1'b1;
          cnt <= cnt + 32'h1;
          if (cnt >= `FPES_CYC_PHASE - 1) begin
            cnt <= 32'h0; fl_dq_oe <= 1'b0; fl_ce_n <= 1'b1;
            if (step < last_step) begin
              step <= step + 3'h1; state <= S_WR;
            end else if (op == `FPES_OP_SECT && cmd_more && cmd_valid) begin
              target <= cmd_addr;
              state <= S_WR;
            end else begin
              fl_addr <= target;
              state <= S_RD;
            end
          end
        end
        // Read strobe; waits for data to settle through the synchroniser
        S_RD: begin
          fl_ce_n <= 1'b0; fl_oe_n <= 1'b0; fl_dq_oe <= 1'b0;
          if (!rb_s)
            rb_low_seen <= 1'b1;
          cnt <= cnt + 32'h1;
          if (cnt >= `FPES_CYC_PHASE + 2) begin
            cnt <= 32'h0; state <= S_CHECK;
          end
        end
        // Judge completion by polling or toggle flags
        S_CHECK: begin
          fl_oe_n <= 1'b1; fl_ce_n <= 1'b1;
          prev_rd <= dq_s; have_prev <= 1'b1;
          rd_data <= dq_s;
          state <= S_RD;
          if (op == `FPES_OP_READ) begin
            result <= `FPES_RES_OK; state <= S_DONE;
          end else if (use_toggle ? (have_prev && !toggling) : poll_done) begin
            result <= `FPES_RES_OK; state <= S_DONE;
          end else if (limit_seen) begin
            result <= `FPES_RES_FAIL; state <= S_DONE;
          end else if (dq_s[`FPES_BIT_LIMIT]) begin
            limit_seen <= 1'b1;
          end else if (op_cnt >= OP_LIMIT) begin
            result <= `FPES_RES_TOOLATE; state <= S_DONE;
          end
        end
        // Reset pulse: long if an algorithm might be running
        S_RST: begin
          fl_reset_n <= 1'b0;
          cnt <= cnt + 32'h1;
          if (cnt >= (step[0] ? `FPES_CYC_RP_ABORT : `FPES_CYC_RP_IDLE) - 1) begin
            fl_reset_n <= 1'b1; cnt <= 32'h0;
            state <= S_PULSE;
          end
        end
        // Protect/unprotect write pulse, or post-reset recovery
        S_PULSE: begin
          cnt <= cnt + 32'h1;
          if (op == `FPES_OP_RESET) begin
            if (cnt >= (step[0] ? `FPES_CYC_READY_AB : `FPES_CYC_RP_IDLE) - 1) begin
              result <= `FPES_RES_OK; state <= S_DONE;
            end
          end else begin
            fl_addr <= target; fl_ce_n <= 1'b0; fl_we_n <= 1'b0;
            // Strobe fell at cnt 0, so the full count keeps it low for the whole minimum
            if (cnt >= ((op == `FPES_OP_PROTECT) ? `FPES_CYC_PROT : UNPROT_CYC)) begin
              fl_we_n <= 1'b1; fl_ce_n <= 1'b1; fl_vid_en <= 1'b0;
              result <= `FPES_RES_OK; state <= S_DONE;
            end
          end
        end
        // High voltage settles before the write pulse
        S_VID: begin
          fl_vid_en <= 1'b1;
          cnt <= cnt + 32'h1;
          if (cnt >= `FPES_CYC_VID - 1) begin
            cnt <= 32'h0; state <= S_PULSE;
          end
        end
        S_DONE: begin
          fl_ce_n <= 1'b1; fl_oe_n <= 1'b1; fl_we_n <= 1'b1; fl_dq_oe <= 1'b0;
          done <= 1'b1; state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fpes_host

/* File: test/fpes_host_monitor.sv */
// Pin-level checker for the flash host controller.
// Assumes it is bound onto fpes_host and sees only that module's ports.
`timescale 1ns/10ps
`include "fpes_defines.vh"
module fpes_host_monitor (
  // Clock and reset
  input wire        mclk,
  input wire        rst_n,
  // Observed ports
  input wire        done,
  input wire [1:0]  result,
  input wire [15:0] rd_data,
  input wire [19:0] fl_addr,
  input wire [15:0] fl_dq_out,
  input wire        fl_dq_oe,
  input wire        fl_ce_n,
  input wire        fl_oe_n,
  input wire        fl_we_n,
  input wire        fl_reset_n,
  input wire        fl_vid_en,
  input wire        ready_busy_output
);
  reg [15:0] rcnt = 16'h0000; // Reset pin low cycles
  reg        rab  = 1'b0;     // Device busy when reset fell
  reg [15:0] wcnt = 16'h0000; // Write strobe low cycles
  reg [15:0] vcnt = 16'h0000; // High voltage on cycles
  // Pulse counters, no reset so a pulse across rst_n still counts
  always @(posedge mclk) begin
    rcnt <= fl_reset_n ? 16'h0000 : rcnt + 16'h0001;
    rab  <= fl_reset_n ? !ready_busy_output : rab;
    wcnt <= fl_we_n ? 16'h0000 : wcnt + 16'h0001;
    vcnt <= fl_vid_en ? vcnt + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rb_we; $fell(fl_we_n) |-> ready_busy_output && $past(ready_busy_output); endproperty
  a_rb_we: assert property (p_rb_we) else $error("write too soon after ready");
  property p_rst_pw; $rose(fl_reset_n) |-> rcnt >= (rab ? 16'h00C8 : 16'h000A); endproperty
  a_rst_pw: assert property (p_rst_pw) else $error("reset pulse too short");
  // Command writes drive data; protect pulses under high voltage leave the bus off
  property p_wr_strb; !fl_we_n |-> !fl_ce_n && fl_oe_n && (fl_dq_oe != fl_vid_en); endproperty
  a_wr_strb: assert property (p_wr_strb) else $error("bad write strobes");
  property p_wr_hold; !fl_we_n && !$past(fl_we_n) |-> $stable(fl_addr) && $stable(fl_dq_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word moved");
  // High voltage drops on the same edge as the strobe rises
  property p_prot_pw; $rose(fl_we_n) && $past(fl_vid_en) |-> wcnt >= 16'h00C8; endproperty
  a_prot_pw: assert property (p_prot_pw) else $error("protect pulse short");
  property p_vid_su; $fell(fl_we_n) && fl_vid_en |-> vcnt >= 16'h0050; endproperty
  a_vid_su: assert property (p_vid_su) else $error("high voltage setup short");
  property p_fail_lim; done && result == `FPES_RES_FAIL |-> rd_data[`FPES_BIT_LIMIT]; endproperty
  a_fail_lim: assert property (p_fail_lim) else $error("fail without limit flag");
  property p_rd_bus; !fl_oe_n |-> fl_we_n && !fl_dq_oe && !fl_ce_n; endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("bad read strobes");
endmodule // fpes_host_monitor
bind fpes_host fpes_host_monitor i_fpes_host_monitor (.mclk(mclk), .rst_n(rst_n),
  .done(done), .result(result), .rd_data(rd_data), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
  .fl_reset_n(fl_reset_n), .fl_vid_en(fl_vid_en), .ready_busy_output(ready_busy_output));

/* File: test/fpes_flash_model.sv */
// Behavioural parallel flash seen by the host controller.
// Assumes word mode; busy times are in 50 ns ticks, kept short.
`timescale 1ns/10ps
module fpes_flash_model #(
  parameter PROG_T  = 40,
  parameter ERASE_T = 100
) (
  // Bus pins
  input  wire [19:0] addr,
  input  wire [15:0] din,
  input  wire        ce_n,
  input  wire        oe_n,
  input  wire        we_n,
  input  wire        reset_n,
  // Fault modes: any set bit means never finishes; bit 0 also raises the limit flag
  input  wire [1:0]  fault,
  output wire [15:0] dout,
  output wire        rb,
  // Observation
  output reg  [15:0] mem,
  output reg  [6:0]  sect
);
  integer    n = 0, bz = 0, wnd = 0;
  reg [15:0] c3 = 16'h0000, pd = 16'h0000, q;
  reg        er = 1'b0, tg = 1'b0;
  initial mem = 16'h1234; // Powers up in read mode
  initial sect = 7'h00;
  assign rb = (bz == 0); // Ready once the algorithm ends
  // Command decode; array changes only after a full sequence
  always @(posedge we_n) if (!ce_n && reset_n && bz == 0) begin
    n = n + 1;
    if (n == 3) c3 = din;
    if (n == 4 && c3 == 16'h00A0) begin
      pd = din; er = 0; bz = PROG_T; n = 0;
    end else if (n == 6 && din == 16'h0010) begin
      er = 1; bz = ERASE_T; n = 0;
    end else if (n >= 6 && din == 16'h0030) begin
      er = 1; sect = addr[18:12]; wnd = 2000; n = 6;
    end else if (din == 16'h00F0 || n > 6) n = 0;
  end
  // Time base; erase waits out the load window
  always #50 begin
    if (!reset_n) begin bz = 0; wnd = 0; n = 0; end
    else if (wnd > 0) begin wnd = wnd - 1; if (wnd == 0) bz = ERASE_T; end
    else if (bz > 0 && fault == 2'h0) begin
      bz = bz - 1;
      if (bz == 0) mem = er ? 16'hFFFF : pd;
    end
  end
  always @(posedge oe_n) if (bz > 0 || wnd > 0) tg = ~tg;
  // Status word while busy, array data otherwise
  always @* begin
    q = mem;
    if (bz > 0 || wnd > 0) q = {8'h00, er ? 1'b0 : ~pd[7], tg, fault[0], 1'b0, bz > 0, tg, 2'b00};
  end
  assign dout = (!oe_n && !ce_n) ? q : ~q; // Released bus shows no stale value
endmodule // fpes_flash_model

/* File: test/tb.sv */
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model on the pins and a 20 MHz mclk.
`timescale 1ns/10ps
`include "fpes_defines.vh"
module tb;
  typedef struct packed {
    logic [2:0] op; logic [19:0] a; logic [15:0] d; logic t; logic [1:0] f;
    logic [1:0] res; logic [15:0] rd; logic c;
  } fpes_row_t;
  fpes_row_t rows [0:9];
  reg        mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_more = 1'b0, cmd_poll_toggle = 1'b0;
  reg [2:0]  cmd_op   = 3'h0;
  reg [19:0] cmd_addr = 20'h00000;
  reg [15:0] cmd_data = 16'h0000;
  reg [1:0]  fault    = 2'h0;
  wire       cmd_ready, done, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_vid_en, rb;
  wire [1:0] result;
  wire [15:0] rd_data, fl_dq_out, fl_dq_in, mem;
  wire [19:0] fl_addr;
  wire [6:0] sect;
  integer    err_count = 0, checks_done = 0, i, k, wl = 0, wmax = 0;
  initial forever #25 mclk = ~mclk;
  fpes_host #(.UNPROT_CYC(32'd300), .OP_LIMIT(32'd20000)) i_fpes_host (.mclk(mclk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_more(cmd_more), .cmd_poll_toggle(cmd_poll_toggle),
    .cmd_ready(cmd_ready), .done(done), .result(result), .rd_data(rd_data),
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n),
    .fl_vid_en(fl_vid_en), .ready_busy_output(rb));
  fpes_flash_model i_fpes_flash_model (.addr(fl_addr), .din(fl_dq_out), .ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n), .reset_n(fl_reset_n), .fault(fault), .dout(fl_dq_in),
    .rb(rb), .mem(mem), .sect(sect));
  // Longest write-strobe low time, for the protect pulses
  always @(posedge mclk) begin
    if (!fl_we_n) wl <= wl + 1;
    else begin
      if (wl > wmax) wmax <= wl;
      wl <= 0;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks=%0d errors=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // One operation: hold the request until taken, then wait for done
  task run(input [2:0] op, input [19:0] a, input [15:0] d, input t);
    begin
      @(posedge mclk);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_poll_toggle <= t;
      cmd_valid <= 1'b1;
      k = 0;
      do begin @(negedge mclk); k = k + 1; end while (cmd_ready !== 1'b1 && k < 30000);
      @(posedge mclk) cmd_valid <= 1'b0;
      do begin @(negedge mclk); k = k + 1; end while (done !== 1'b1 && k < 30000);
      if (k >= 30000) err_count = err_count + 1;
    end
  endtask
  initial begin
    #3000000;
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    rows[0] = '{`FPES_OP_PROG, 20'h01234, 16'h5A3C, 1'b0, 2'h0, `FPES_RES_OK, 16'h5A3C, 1'b1};
    rows[1] = '{`FPES_OP_READ, 20'h01234, 16'h0000, 1'b0, 2'h0, `FPES_RES_OK, 16'h5A3C, 1'b1};
    rows[2] = '{`FPES_OP_PROG, 20'h01234, 16'h00C3, 1'b1, 2'h0, `FPES_RES_OK, 16'h00C3, 1'b1};
    rows[3] = '{`FPES_OP_CHIP, 20'h00000, 16'h0000, 1'b0, 2'h0, `FPES_RES_OK, 16'hFFFF, 1'b1};
    rows[4] = '{`FPES_OP_SECT, 20'h5F000, 16'h0000, 1'b1, 2'h0, `FPES_RES_OK, 16'hFFFF, 1'b1};
    rows[5] = '{`FPES_OP_PROG, 20'h00010, 16'h0055, 1'b0, 2'h1, `FPES_RES_FAIL, 16'h0000, 1'b0};
    rows[6] = '{`FPES_OP_RESET, 20'h00000, 16'h0000, 1'b0, 2'h1, `FPES_RES_OK, 16'h0000, 1'b0};
    rows[7] = '{`FPES_OP_PROG, 20'h00020, 16'h0011, 1'b1, 2'h2, `FPES_RES_TOOLATE, 16'h0, 1'b0};
    rows[8] = '{`FPES_OP_RESET, 20'h00000, 16'h0000, 1'b0, 2'h2, `FPES_RES_OK, 16'h0000, 1'b0};
    rows[9] = '{`FPES_OP_RESET, 20'h00000, 16'h0000, 1'b0, 2'h0, `FPES_RES_OK, 16'h0000, 1'b0};
    repeat (5) @(negedge mclk);
    // Reset keeps the strobes quiet and the port closed
    chk({11'h000, cmd_ready, done, fl_we_n, fl_dq_oe, fl_vid_en}, 16'h0004);
    @(posedge mclk) rst_n <= 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      fault <= rows[i].f;
      run(rows[i].op, rows[i].a, rows[i].d, rows[i].t);
      chk({14'h0000, result}, {14'h0000, rows[i].res});
      if (rows[i].c) chk(rd_data, rows[i].rd);
      $display("test %0d done", i);
    end
    chk({9'h000, sect}, 16'h005F);
    // Two sectors in one erase: second address offered with cmd_more
    @(posedge mclk);
    cmd_op <= `FPES_OP_SECT;
    cmd_addr <= 20'h11000;
    cmd_poll_toggle <= 1'b0;
    cmd_more <= 1'b1;
    cmd_valid <= 1'b1;
    do @(negedge mclk); while (cmd_ready !== 1'b1);
    do @(negedge mclk); while (cmd_ready !== 1'b0);
    @(posedge mclk) cmd_addr <= 20'h23000;
    do @(negedge mclk); while (!(fl_we_n === 1'b0 && fl_addr === 20'h23000));
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_more <= 1'b0;
    do @(negedge mclk); while (done !== 1'b1);
    chk({14'h0000, result}, {14'h0000, `FPES_RES_OK});
    chk(rd_data, 16'hFFFF);
    chk({9'h000, sect}, 16'h0023);
    $display("test two sectors done");
    wmax = 0;
    run(`FPES_OP_PROTECT, 20'h3F000, 16'h0000, 1'b0);
    chk({15'h0000, wmax >= 200}, 16'h0001);
    $display("test protect done");
    wmax = 0;
    run(`FPES_OP_UNPROTECT, 20'h00000, 16'h0000, 1'b0);
    chk({15'h0000, wmax >= 300}, 16'h0001);
    $display("test unprotect done");
    // Reset in mid-write: strobes drop at once, port reopens after release
    @(posedge mclk);
    cmd_op <= `FPES_OP_CHIP;
    cmd_valid <= 1'b1;
    do @(negedge mclk); while (fl_we_n !== 1'b0);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    rst_n <= 1'b0;
    @(negedge mclk);
    chk({11'h000, cmd_ready, done, fl_we_n, fl_dq_oe, fl_vid_en}, 16'h0004);
    @(posedge mclk) rst_n <= 1'b1;
    repeat (2) @(negedge mclk);
    chk({15'h0000, cmd_ready}, 16'h0001);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule // tb
